//--- hw/reg_cmd_exec.sv
// small parameter store behind the remote register commands
`default_nettype none
module reg_cmd_exec
    import rio_pkg::*;
#(
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // request
    input wire logic go,
    input wire logic [CODE_W-1:0] code,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    // monitor source
    input wire logic [DATA_W-1:0] monitor_value,
    // answer
    output logic [DATA_W-1:0] rdata,
    output logic err
);
    localparam int AW = $clog2(DEPTH);
    logic [DATA_W-1:0] mem [DEPTH];
    wire logic [1:0] cat;
    wire logic in_range;
    assign cat = code[CODE_W-1 -: 2];
    assign in_range = (addr < ADDR_W'(DEPTH));

    always_ff @(posedge mclk) begin
        if (go && cat == CAT_PARAM_WR && in_range) begin
            mem[addr[AW-1:0]] <= wdata;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
            err <= 1'b0;
        end else if (go) begin
            unique case (cat)
                CAT_PARAM_RD: rdata <= in_range ? mem[addr[AW-1:0]] : '0;
                CAT_PARAM_WR: rdata <= wdata;
                CAT_MONITOR: rdata <= monitor_value;
                CAT_MAINT: rdata <= '0;
            endcase
            err <= (cat == CAT_PARAM_RD || cat == CAT_PARAM_WR) && !in_range;
        end
    end
endmodule // reg_cmd_exec

//--- hw/remote_io_register_handshake.sv
// remote i/o words and remote register handshake of the drive network port
`default_nettype none
module remote_io_register_handshake
    import rio_pkg::*;
#(
    parameter int WIDTH = IO_WIDE,
    parameter int DEPTH = 16,
    parameter int EXEC_CYCLES = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // connection mode, high selects the sixteen-axis narrow words
    input wire logic narrow_mode,
    // remote i/o
    input wire logic [WIDTH-1:0] net_input_bit,
    output logic [WIDTH-1:0] net_output_bit,
    // remote register
    input wire cmd_frame_t cmd_in,
    output var rsp_frame_t rsp_out,
    // drive core side
    input wire drive_stat_t stat,
    input wire logic [DATA_W-1:0] monitor_value,
    output var motion_req_t req,
    output logic [2:0] select_bit_echo,
    output logic command_busy
);
    typedef enum logic [1:0] {IDLE, EXEC, DONE} hs_state_t;
    localparam int CNT_W = $clog2(EXEC_CYCLES + 1);

    hs_state_t state_r, state_nxt;
    logic strobe_d_r;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [CODE_W-1:0] code_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic [DATA_W-1:0] rdata;
    logic err;
    logic [WIDTH-1:0] map_out;
    motion_req_t map_req;
    logic run_echo_r;

    wire logic command_strobe;
    wire logic [CODE_W-1:0] code_in;
    wire logic strobe_rise;
    wire logic go;
    wire logic command_done_strobe;
    wire logic [7:0] resp_byte;

    assign command_strobe = cmd_in.ctrl[CMD_STROBE_BIT];
    assign code_in = cmd_in.ctrl[CODE_W-1:0];
    assign strobe_rise = command_strobe && !strobe_d_r;
    assign go = (state_r == EXEC) && (cnt_r == CNT_W'(EXEC_CYCLES - 1));
    // from the registered state: the executor answers on the go edge, so done
    // must wait one more edge to leave together with its data and status
    assign command_done_strobe = (state_r == DONE);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            IDLE: begin
                cnt_nxt = '0;
                if (strobe_rise) begin
                    state_nxt = EXEC;
                end
            end
            EXEC: begin
                cnt_nxt = cnt_r + CNT_W'(1);
                if (go) begin
                    state_nxt = DONE;
                end
            end
            DONE: begin
                if (!command_strobe) begin
                    state_nxt = IDLE;
                end
            end
            default: begin
                state_nxt = IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= IDLE;
            cnt_r <= '0;
            strobe_d_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            strobe_d_r <= command_strobe;
        end
    end

    // capture payload, byte 0 is least significant
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            code_r <= '0;
            addr_r <= '0;
            wdata_r <= '0;
        end else if (state_r == IDLE && strobe_rise) begin
            code_r <= code_in;
            addr_r <= cmd_in.addr;
            wdata_r <= cmd_in.data;
        end
    end

    reg_cmd_exec #(.DEPTH(DEPTH)) u_exec (
        .mclk(mclk),
        .rst_n(rst_n),
        .go(go),
        .code(code_r),
        .addr(addr_r),
        .wdata(wdata_r),
        .monitor_value(monitor_value),
        .rdata(rdata),
        .err(err)
    );

    // response byte layout with echoed code
    assign resp_byte = {err, command_done_strobe, code_r};

    // response held back until done so data and status are valid with it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_out <= '0;
        end else begin
            rsp_out.resp <= resp_byte;
            rsp_out.addr <= addr_r;
            rsp_out.data <= rdata;
        end
    end

    rio_word_map #(.WIDTH(WIDTH)) u_map (
        .net_input_bit(net_input_bit),
        .narrow_mode(narrow_mode),
        .net_output_bit(map_out),
        .stat(stat),
        .select_bit_echo(select_bit_echo),
        .run_echo(run_echo_r),
        .req(map_req)
    );

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            net_output_bit <= '0;
            req <= '0;
            select_bit_echo <= '0;
            run_echo_r <= 1'b0;
            command_busy <= 1'b0;
        end else begin
            net_output_bit <= map_out;
            req <= map_req;
            select_bit_echo <= map_req.data_sel;
            run_echo_r <= map_req.start;
            command_busy <= (state_nxt == EXEC);
        end
    end

    property p_done_after_exec;
        @(posedge mclk) disable iff (!rst_n)
        (state_r == IDLE && strobe_rise) |-> ##(EXEC_CYCLES + 2) rsp_out.resp[RSP_DONE_BIT];
    endproperty
    a_done_after_exec: assert property (p_done_after_exec) else $error("done late");

    property p_no_start_without_edge;
        @(posedge mclk) disable iff (!rst_n)
        (state_r == IDLE && !strobe_rise) |=> state_r == IDLE;
    endproperty
    a_no_start_without_edge: assert property (p_no_start_without_edge)
        else $error("start without edge");

    property p_code_echo;
        @(posedge mclk) disable iff (!rst_n)
        (state_r == IDLE && strobe_rise) |-> ##(EXEC_CYCLES + 2)
            rsp_out.resp[CODE_W-1:0] == $past(code_in, EXEC_CYCLES + 2);
    endproperty
    a_code_echo: assert property (p_code_echo) else $error("code not echoed");

    property p_done_clears;
        @(posedge mclk) disable iff (!rst_n)
        (state_r == DONE && !command_strobe) |=> ##1 !rsp_out.resp[RSP_DONE_BIT];
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("done stuck");

    property p_status_err;
        @(posedge mclk) disable iff (!rst_n)
        go |=> ##1 rsp_out.resp[RSP_STATUS_BIT] == err;
    endproperty
    a_status_err: assert property (p_status_err) else $error("status mismatch");

    property p_narrow_upper;
        @(posedge mclk) disable iff (!rst_n)
        narrow_mode |=> net_output_bit[WIDTH-1:IO_NARROW] == '0;
    endproperty
    a_narrow_upper: assert property (p_narrow_upper) else $error("upper byte live");

    property p_fault_out;
        @(posedge mclk) disable iff (!rst_n)
        stat.fault |=> net_output_bit[OUT_FAULT];
    endproperty
    a_fault_out: assert property (p_fault_out) else $error("fault not shown");

    property p_stop_req;
        @(posedge mclk) disable iff (!rst_n)
        net_input_bit[IN_STOP] |=> req.stop;
    endproperty
    a_stop_req: assert property (p_stop_req) else $error("stop lost");

    property p_cont_neg;
        @(posedge mclk) disable iff (!rst_n)
        (!narrow_mode && net_input_bit[IN_CONT_NEG]) |=> req.cont_neg;
    endproperty
    a_cont_neg: assert property (p_cont_neg) else $error("negative run lost");

    property p_lost_sync;
        @(posedge mclk) disable iff (!rst_n)
        (!narrow_mode && stat.lost_sync)
            |=> net_output_bit[OUT_LOST_SYNC] && !net_output_bit[OUT_UNUSED];
    endproperty
    a_lost_sync: assert property (p_lost_sync) else $error("lost sync not shown");

    property p_busy_exec;
        @(posedge mclk) disable iff (!rst_n)
        (state_r == IDLE && strobe_rise) |=> command_busy;
    endproperty
    a_busy_exec: assert property (p_busy_exec) else $error("busy not raised");

    property p_idle_no_busy;
        @(posedge mclk) disable iff (!rst_n)
        (state_r == IDLE && !strobe_rise) |=> !command_busy;
    endproperty
    a_idle_no_busy: assert property (p_idle_no_busy) else $error("busy while idle");

    property p_busy_drops;
        @(posedge mclk) disable iff (!rst_n)
        go |=> !command_busy;
    endproperty
    a_busy_drops: assert property (p_busy_drops) else $error("busy stuck");

    // a done that leaves ahead of the executor would carry the previous answer
    property p_data_with_done;
        @(posedge mclk) disable iff (!rst_n)
        $rose(rsp_out.resp[RSP_DONE_BIT]) |-> rsp_out.data == rdata;
    endproperty
    a_data_with_done: assert property (p_data_with_done) else $error("stale data");

    property p_status_with_done;
        @(posedge mclk) disable iff (!rst_n)
        $rose(rsp_out.resp[RSP_DONE_BIT]) |-> rsp_out.resp[RSP_STATUS_BIT] == err;
    endproperty
    a_status_with_done: assert property (p_status_with_done) else $error("stale status");

    property p_done_stands;
        @(posedge mclk) disable iff (!rst_n)
        (state_r == DONE && command_strobe) |=> rsp_out.resp[RSP_DONE_BIT];
    endproperty
    a_done_stands: assert property (p_done_stands) else $error("done dropped early");

    // edges during execution or while done stands must not reload the command
    property p_refuse_retrigger;
        @(posedge mclk) disable iff (!rst_n)
        (state_r != IDLE) |=> $stable(code_r);
    endproperty
    a_refuse_retrigger: assert property (p_refuse_retrigger) else $error("code reloaded");

    property p_narrow_req;
        @(posedge mclk) disable iff (!rst_n)
        narrow_mode |=> req.direct_sel == '0 && !req.seq_req && !req.inch_pos
            && !req.inch_neg && !req.cont_pos && !req.cont_neg;
    endproperty
    a_narrow_req: assert property (p_narrow_req) else $error("upper request live");

    property p_echo_out;
        @(posedge mclk) disable iff (!rst_n)
        net_output_bit[OUT_ECHO0 +: IN_SEL_N] == $past(select_bit_echo);
    endproperty
    a_echo_out: assert property (p_echo_out) else $error("select echo not shown");
endmodule // remote_io_register_handshake
`default_nettype wire

//--- hw/rio_pkg.sv
// shared types and constants for the remote i/o and register handshake block
`default_nettype none
package rio_pkg;
    localparam int IO_WIDE = 16;
    localparam int IO_NARROW = 8;
    localparam int CODE_W = 6;
    localparam int DATA_BYTES = 4;
    localparam int DATA_W = DATA_BYTES * 8;
    localparam int ADDR_W = 16;
    // command control byte layout
    localparam int CMD_STROBE_BIT = 6;
    localparam int CMD_UNUSED_BIT = 7;
    // response byte layout
    localparam int RSP_STATUS_BIT = 7;
    localparam int RSP_DONE_BIT = 6;
    // default input bit functions
    localparam int IN_SEL0 = 0;
    localparam int IN_SEL_N = 3;
    localparam int IN_START = 3;
    localparam int IN_HOME = 4;
    localparam int IN_STOP = 5;
    localparam int IN_FREE = 6;
    localparam int IN_FAULT_CLR = 7;
    localparam int IN_DPOS0 = 8;
    localparam int IN_DPOS_N = 3;
    localparam int IN_SEQ = 11;
    localparam int IN_INCH_POS = 12;
    localparam int IN_INCH_NEG = 13;
    localparam int IN_CONT_POS = 14;
    localparam int IN_CONT_NEG = 15;
    // default output bit functions
    localparam int OUT_ECHO0 = 0;
    localparam int OUT_RUN_ECHO = 3;
    localparam int OUT_ORIGIN = 4;
    localparam int OUT_READY = 5;
    localparam int OUT_CAUTION = 6;
    localparam int OUT_FAULT = 7;
    localparam int OUT_BUSY = 8;
    localparam int OUT_ZONE0 = 9;
    localparam int OUT_ZONE_N = 3;
    localparam int OUT_PHASE = 12;
    localparam int OUT_MOVING = 13;
    localparam int OUT_UNUSED = 14;
    localparam int OUT_LOST_SYNC = 15;
    // command code categories, top two bits of the code
    localparam logic [1:0] CAT_PARAM_RD = 2'h0;
    localparam logic [1:0] CAT_PARAM_WR = 2'h1;
    localparam logic [1:0] CAT_MONITOR = 2'h2;
    localparam logic [1:0] CAT_MAINT = 2'h3;
    localparam logic [1:0] STATUS_OK = 2'h0;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [ADDR_W-1:0] addr;
        logic [7:0] ctrl;
    } cmd_frame_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [ADDR_W-1:0] addr;
        logic [7:0] resp;
    } rsp_frame_t;

    typedef struct packed {
        logic [2:0] data_sel;
        logic start;
        logic home;
        logic stop;
        logic release_brake;
        logic fault_clear;
        logic [2:0] direct_sel;
        logic seq_req;
        logic inch_pos;
        logic inch_neg;
        logic cont_pos;
        logic cont_neg;
    } motion_req_t;

    typedef struct packed {
        logic origin;
        logic ready;
        logic caution;
        logic fault;
        logic busy;
        logic [2:0] zone;
        logic phase;
        logic moving;
        logic lost_sync;
    } drive_stat_t;
endpackage
`default_nettype wire

//--- hw/rio_word_map.sv
// default function mapping of the remote input and output words
`default_nettype none
module rio_word_map
    import rio_pkg::*;
#(
    parameter int WIDTH = IO_WIDE
) (
    // network side words
    input wire logic [WIDTH-1:0] net_input_bit,
    input wire logic narrow_mode,
    output logic [WIDTH-1:0] net_output_bit,
    // drive side
    input wire drive_stat_t stat,
    input wire logic [2:0] select_bit_echo,
    input wire logic run_echo,
    output var motion_req_t req
);
    // upper byte is masked in narrow mode so stale bits cannot act
    wire logic [WIDTH-1:0] in_eff;
    assign in_eff = narrow_mode ? {{(WIDTH-IO_NARROW){1'b0}}, net_input_bit[IO_NARROW-1:0]}
                                : net_input_bit;

    assign req.data_sel = in_eff[IN_SEL0 +: IN_SEL_N];
    assign req.start = in_eff[IN_START];
    assign req.home = in_eff[IN_HOME];
    assign req.stop = in_eff[IN_STOP];
    assign req.release_brake = in_eff[IN_FREE];
    assign req.fault_clear = in_eff[IN_FAULT_CLR];
    assign req.direct_sel = in_eff[IN_DPOS0 +: IN_DPOS_N];
    assign req.seq_req = in_eff[IN_SEQ];
    assign req.inch_pos = in_eff[IN_INCH_POS];
    assign req.inch_neg = in_eff[IN_INCH_NEG];
    assign req.cont_pos = in_eff[IN_CONT_POS];
    assign req.cont_neg = in_eff[IN_CONT_NEG];

    wire logic [IO_WIDE-1:0] out_full;
    assign out_full[OUT_ECHO0 +: IN_SEL_N] = select_bit_echo;
    assign out_full[OUT_RUN_ECHO] = run_echo;
    assign out_full[OUT_ORIGIN] = stat.origin;
    assign out_full[OUT_READY] = stat.ready;
    assign out_full[OUT_CAUTION] = stat.caution;
    assign out_full[OUT_FAULT] = stat.fault;
    assign out_full[OUT_BUSY] = stat.busy;
    assign out_full[OUT_ZONE0 +: OUT_ZONE_N] = stat.zone;
    assign out_full[OUT_PHASE] = stat.phase;
    assign out_full[OUT_MOVING] = stat.moving;
    assign out_full[OUT_UNUSED] = 1'b0;
    assign out_full[OUT_LOST_SYNC] = stat.lost_sync;

    assign net_output_bit = narrow_mode
        ? {{(WIDTH-IO_NARROW){1'b0}}, out_full[IO_NARROW-1:0]} : out_full[WIDTH-1:0];
endmodule // rio_word_map

//--- verification/net_converter_model.sv
// behavioural network converter driving the remote register command side
`default_nettype none
module net_converter_model
    import rio_pkg::*;
(
    // clock
    input wire logic mclk,
    // remote register frames
    input wire rsp_frame_t rsp_out,
    output var cmd_frame_t cmd_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cmd_in = '0;

    // one full handshake; lat_done counts edges from launch, lat_clear from strobe drop
    task automatic do_cmd(input logic [5:0] code, input logic [15:0] addr,
                          input logic [31:0] wdata, input logic spare,
                          output rsp_frame_t rsp, output int lat_done, output int lat_clear);
        lat_done = 0;
        lat_clear = 0;
        @(posedge mclk);
        #1;
        cmd_in.ctrl = {spare, 1'b1, code};
        cmd_in.addr = addr;
        cmd_in.data = wdata;
        while (rsp_out.resp[6] !== 1'b1 && lat_done < 40) begin
            @(posedge mclk);
            #1;
            lat_done++;
        end
        rsp = rsp_out;
        cmd_in.ctrl[6] = 1'b0;
        // released lines show the inverse so stale data cannot pass as valid
        cmd_in.addr = ~cmd_in.addr;
        cmd_in.data = ~cmd_in.data;
        while (rsp_out.resp[6] !== 1'b0 && lat_clear < 40) begin
            @(posedge mclk);
            #1;
            lat_clear++;
        end
    endtask

    // code changes with the strobe held low; reports whether done ever rose
    task automatic hold_idle(input logic [5:0] code, input int n, output logic seen);
        seen = 1'b0;
        @(posedge mclk);
        #1;
        cmd_in.ctrl = {1'b0, 1'b0, code};
        repeat (n) begin
            @(posedge mclk);
            #1;
            if (rsp_out.resp[6] !== 1'b0) seen = 1'b1;
            cmd_in.ctrl[5:0] = ~cmd_in.ctrl[5:0];
        end
    endtask
endmodule // net_converter_model
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the remote i/o and register handshake block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rio_pkg::*;

    localparam int EXEC = 2;
    localparam int DEPTH = 16;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic narrow_mode = 1'b0;
    logic [15:0] net_input_bit = '0;
    logic [15:0] net_output_bit;
    drive_stat_t stat = '0;
    logic [31:0] monitor_value = '0;
    cmd_frame_t cmd_in;
    rsp_frame_t rsp_out;
    motion_req_t req;
    logic [2:0] select_bit_echo;
    logic command_busy;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;

    remote_io_register_handshake #(.WIDTH(16), .DEPTH(DEPTH), .EXEC_CYCLES(EXEC))
        u_remote_io_register_handshake (
        .mclk(mclk), .rst_n(rst_n), .narrow_mode(narrow_mode),
        .net_input_bit(net_input_bit), .net_output_bit(net_output_bit),
        .cmd_in(cmd_in), .rsp_out(rsp_out), .stat(stat), .monitor_value(monitor_value),
        .req(req), .select_bit_echo(select_bit_echo), .command_busy(command_busy)
    );
    net_converter_model u_net_converter_model (.mclk(mclk), .rsp_out(rsp_out), .cmd_in(cmd_in));

    always #25 mclk = ~mclk;

    // ceiling well above the hundred or so cycles the scenarios need
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic motion_req_t mk_req(input logic [15:0] w);
        motion_req_t r;
        r.data_sel = w[2:0];
        r.start = w[3];
        r.home = w[4];
        r.stop = w[5];
        r.release_brake = w[6];
        r.fault_clear = w[7];
        r.direct_sel = w[10:8];
        r.seq_req = w[11];
        r.inch_pos = w[12];
        r.inch_neg = w[13];
        r.cont_pos = w[14];
        r.cont_neg = w[15];
        return r;
    endfunction

    function automatic logic [15:0] mk_out(input logic [15:0] w, input drive_stat_t s);
        return {s.lost_sync, 1'b0, s.moving, s.phase, s.zone, s.busy,
                s.fault, s.caution, s.ready, s.origin, w[3], w[2:0]};
    endfunction

    // complementary patterns so every bit is seen at both levels
    task automatic t_io(input logic narrow);
        logic [15:0] pat [2];
        motion_req_t er;
        logic [15:0] eo;
        pat[0] = 16'ha5c3;
        pat[1] = 16'h5a3c;
        foreach (pat[i]) begin
            @(posedge mclk);
            #1;
            net_input_bit = pat[i];
            narrow_mode = narrow;
            stat = drive_stat_t'(pat[i][10:0] ^ 11'h2b6);
            repeat (3) @(posedge mclk);
            #1;
            er = mk_req(pat[i]);
            eo = mk_out(pat[i], stat);
            chk({29'h0, select_bit_echo}, {29'h0, pat[i][2:0]}, "select echo");
            if (narrow) begin
                // the low-byte functions sit in the upper half of the packed request
                chk({24'h0, req[15:8]}, {24'h0, er[15:8]}, "narrow req");
                chk({24'h0, req[7:0]}, 32'h0, "narrow upper req");
                chk({16'h0, net_output_bit}, {16'h0, eo & 16'h00ff}, "narrow out");
            end else begin
                chk({16'h0, req}, {16'h0, er}, "wide req");
                chk({16'h0, net_output_bit}, {16'h0, eo}, "wide out");
            end
        end
        narrow_mode = 1'b0;
    endtask

    task automatic t_cmd(input logic [5:0] code, input logic [15:0] addr, input logic [31:0] wd,
                         input logic spare, input logic est, input logic [31:0] ed,
                         input logic use_d);
        rsp_frame_t r;
        int ld;
        int lc;
        u_net_converter_model.do_cmd(code, addr, wd, spare, r, ld, lc);
        chk({31'h0, r.resp[6]}, 32'h1, "done strobe");
        chk({31'h0, r.resp[7]}, {31'h0, est}, "status");
        chk({26'h0, r.resp[5:0]}, {26'h0, code}, "code echo");
        // take edge, then EXEC_CYCLES+1 to done
        chk(ld, EXEC + 2, "done latency");
        // strobe-low sampling edge, then the response register clears
        chk(lc, 2, "done clear");
        chk({31'h0, command_busy}, 32'h0, "busy after");
        if (use_d) chk(r.data, ed, "read data");
    endtask

    task automatic t_no_rise();
        logic seen;
        u_net_converter_model.hold_idle(6'h20, 8, seen);
        chk({31'h0, seen}, 32'h0, "no strobe no done");
        chk({31'h0, command_busy}, 32'h0, "no strobe no busy");
    endtask

    initial begin
        repeat (12) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        monitor_value = 32'h89ab_cdef;
        t_io(1'b0);
        t_io(1'b1);
        t_no_rise();
        // write with unused bit 7 set must behave as a plain write
        t_cmd(6'h15, 16'h0003, 32'h1122_3344, 1'b1, 1'b0, '0, 1'b0);
        t_cmd(6'h02, 16'h0003, 32'hffff_ffff, 1'b0, 1'b0, 32'h1122_3344, 1'b1);
        t_cmd(6'h10, 16'(DEPTH - 1), 32'h0000_00a5, 1'b0, 1'b0, '0, 1'b0);
        t_cmd(6'h01, 16'(DEPTH - 1), 32'h0, 1'b0, 1'b0, 32'h0000_00a5, 1'b1);
        t_cmd(6'h00, 16'(DEPTH), 32'h0, 1'b0, 1'b1, '0, 1'b0);
        t_cmd(6'h1f, 16'(DEPTH), 32'h5555_aaaa, 1'b0, 1'b1, '0, 1'b0);
        t_cmd(6'h2a, 16'h0000, 32'h0, 1'b0, 1'b0, 32'h89ab_cdef, 1'b1);
        t_cmd(6'h3f, 16'h0000, 32'h1234_5678, 1'b0, 1'b0, 32'h0, 1'b1);
        t_cmd(6'h02, 16'h0003, 32'h0, 1'b0, 1'b0, 32'h1122_3344, 1'b1);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
